// ---- rtl/dtec_regs.svh ----
// Purpose: Register map, field positions and counts for dtec_top
// Assumes: Byte-wide special-function-register bus
// Notes: Definitions only
`ifndef DTEC_REGS_SVH
`define DTEC_REGS_SVH

// Register addresses
`define DTEC_ADDR_CTRL 8'h88
`define DTEC_ADDR_MODE 8'h89
`define DTEC_ADDR_LO0 8'h8a
`define DTEC_ADDR_HI0 8'h8c
`define DTEC_ADDR_CLKSEL 8'h8e

// Reset values
`define DTEC_CTRL_RST 8'h00
`define DTEC_MODE_RST 8'h00
`define DTEC_CLKSEL_RST 8'h01
`define DTEC_RDATA_RST 8'h00

// Run and flag control fields, timer or pin k at base + 2*k
`define DTEC_TF_BASE 5
`define DTEC_TR_BASE 4
`define DTEC_IE_BASE 1
`define DTEC_IT_BASE 0

// Mode selection fields, timer k in nibble k
`define DTEC_GATE_BIT 3
`define DTEC_CT_BIT 2
// Clock-divide select, timer k at base + k
`define DTEC_DIVSEL_BASE 3
`define DTEC_CLKSEL_MASK 8'h3f

// Internal tick divider
`define DTEC_DIV_W 4
`define DTEC_DIV12_LAST 4'hb
`define DTEC_DIV4_LAST 2'h3

// Count limits
`define DTEC_BYTE_MAX 8'hff
`define DTEC_PRESCALE_MAX 5'h1f
`define DTEC_ONE16 16'h0001
`define DTEC_ONE8 8'h01
`define DTEC_ONE5 5'h01

`endif

// ---- rtl/dtec_pkg.sv ----
// Purpose: Types shared by the dual timer and interrupt control
// Assumes: Nothing beyond the register header
// Notes: Field order of the structs is fixed; ports depend on it
package dtec_pkg;

   // Register bus request from the core
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } dtec_sfr_req_t;

   // One bit per interrupt source
   typedef struct packed {
      logic tmr1;
      logic ext1;
      logic tmr0;
      logic ext0;
   } dtec_irq_t;

   // Timer operating modes
   typedef enum logic [1:0] {
      DTEC_MODE_13BIT = 2'b00,
      DTEC_MODE_16BIT = 2'b01,
      DTEC_MODE_RELOAD = 2'b10,
      DTEC_MODE_HALT = 2'b11
   } dtec_mode_t;

endpackage

// ---- rtl/dtec_top.sv ----
// Purpose: Two 16-bit timer/counters and two external interrupt inputs
// Assumes: Pins synchronous to sys_clk except the count pins
// Notes: Register writes win over counting in the same cycle
//
// Overview of operation
// - Timer one overflow past its mode limit sets its overflow flag.
// - Timer zero overflow past its mode limit sets its overflow flag.
// - Timer one flag cleared by software write or by vector acknowledge.
// - Timer zero flag cleared by software write or by vector acknowledge.
// - Timer one run bit low holds its count; high lets it count.
// - Timer zero run bit low holds its count; high lets it count.
// - Interrupt one edge mode: flag set on edge until cleared or vectored.
// - Interrupt one level mode: flag shows inverse of its pin.
// - Interrupt one type bit: 0 level, 1 edge detection.
// - Interrupt zero edge mode: flag set on edge until cleared or vectored.
// - Interrupt zero level mode: flag shows inverse of its pin.
// - Interrupt zero type bit: 0 level, 1 edge detection.
// - Timer one gate high makes counting also need interrupt one pin high.
// - Timer one source bit: 0 internal ticks, 1 count pin pulses.
// - Idle mode freezes both timers.
// - Mode 00 13-bit, 01 16-bit, 10 8-bit reload, 11 halted.
// - Timer zero gate high makes counting also need interrupt zero pin high.
// - Timer zero source bit: 0 internal ticks, 1 count pin pulses.
// - Internal tick is clock divided by 12, or by 4 when selected.
`timescale 1ns/1ps
`include "dtec_regs.svh"

module dtec_top (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // Register bus
   input wire dtec_pkg::dtec_sfr_req_t sfr_req,
   output logic [7:0] sfr_rdata,
   // Core state and interrupt vectoring
   input wire logic cpu_idle,
   input wire dtec_pkg::dtec_irq_t irq_ack,
   output dtec_pkg::dtec_irq_t irq_req,
   // Device pins
   input wire logic ext_irq_zero_pin,
   input wire logic ext_irq_one_pin,
   input wire logic timer_zero_count_pin,
   input wire logic timer_one_count_pin
);

   logic [7:0] ctrl_reg;
   logic [7:0] ctrl_next;
   logic [7:0] mode_reg;
   logic [7:0] clksel_reg;
   logic [7:0] rdata_reg;
   logic [`DTEC_DIV_W-1:0] div_reg;
   logic [1:0] int_prev_reg;
   logic [1:0] int_pin;
   logic [1:0] int_fall;
   logic [1:0] cnt_pin;
   logic [1:0] ack_tmr;
   logic [1:0] ack_ext;
   logic [1:0] ovf_w;
   logic [1:0] inc_w;
   logic tick12;
   logic tick4;
   logic ctrl_wr;
   wire [7:0] lo_q [0:1];
   wire [7:0] hi_q [0:1];

   // Pin and acknowledge vectors, index 0 is timer or interrupt zero
   assign int_pin = {ext_irq_one_pin, ext_irq_zero_pin};
   assign cnt_pin = {timer_one_count_pin, timer_zero_count_pin};
   assign ack_tmr = {irq_ack.tmr1, irq_ack.tmr0};
   assign ack_ext = {irq_ack.ext1, irq_ack.ext0};
   assign ctrl_wr = sfr_req.wr && (sfr_req.addr == `DTEC_ADDR_CTRL);

   // Shared prescaler; one counter serves both rates
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         div_reg <= '0;
      end else if (div_reg == `DTEC_DIV12_LAST) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_reg + `DTEC_DIV_W'(1);
      end
   end

   assign tick12 = (div_reg == `DTEC_DIV12_LAST);
   assign tick4 = (div_reg[1:0] == `DTEC_DIV4_LAST);

   // Interrupt pin history for falling-edge detection
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         int_prev_reg <= '1;
      end else begin
         int_prev_reg <= int_pin;
      end
   end

   assign int_fall = int_prev_reg & ~int_pin;

   // Mode and clock-select registers
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         mode_reg <= `DTEC_MODE_RST;
      end else if (sfr_req.wr && sfr_req.addr == `DTEC_ADDR_MODE) begin
         mode_reg <= sfr_req.wdata;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         clksel_reg <= `DTEC_CLKSEL_RST;
      end else if (sfr_req.wr && sfr_req.addr == `DTEC_ADDR_CLKSEL) begin
         clksel_reg <= sfr_req.wdata & `DTEC_CLKSEL_MASK;
      end
   end

   // Per-timer counting
   for (genvar i = 0; i < 2; i++) begin : g_tmr
      localparam logic [7:0] LO_ADDR = 8'(`DTEC_ADDR_LO0 + i);
      localparam logic [7:0] HI_ADDR = 8'(`DTEC_ADDR_HI0 + i);
      logic [7:0] lo_reg;
      logic [7:0] hi_reg;
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic [3:0] nib;
      dtec_pkg::dtec_mode_t mode;
      logic fall;
      logic src_tick;
      logic open;
      logic inc;
      logic ovf;
      logic wr_lo;
      logic wr_hi;

      // Count pin is asynchronous; third stage feeds the edge detector
      always_ff @(posedge sys_clk) begin
         if (srst) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
         end else begin
            s1_reg <= cnt_pin[i];
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
         end
      end

      assign fall = s3_reg & ~s2_reg;
      assign nib = mode_reg[i*4 +: 4];
      assign mode = dtec_pkg::dtec_mode_t'(nib[1:0]);
      // Source select: pin pulses or divided system clock
      assign src_tick = nib[`DTEC_CT_BIT] ? fall
         : (clksel_reg[`DTEC_DIVSEL_BASE + i] ? tick4 : tick12);
      // Gate lets the interrupt pin hold the timer off
      assign open = ~nib[`DTEC_GATE_BIT] | int_pin[i];
      assign inc = ctrl_reg[`DTEC_TR_BASE + 2*i]
         & open & ~cpu_idle
         & (mode != dtec_pkg::DTEC_MODE_HALT) & src_tick;
      assign wr_lo = sfr_req.wr && (sfr_req.addr == LO_ADDR);
      assign wr_hi = sfr_req.wr && (sfr_req.addr == HI_ADDR);

      // Overflow at the limit of the current mode
      always_comb begin
         unique case (mode)
            dtec_pkg::DTEC_MODE_13BIT: begin
               ovf = inc && hi_reg == `DTEC_BYTE_MAX
                  && lo_reg[4:0] == `DTEC_PRESCALE_MAX;
            end
            dtec_pkg::DTEC_MODE_16BIT: begin
               ovf = inc && hi_reg == `DTEC_BYTE_MAX
                  && lo_reg == `DTEC_BYTE_MAX;
            end
            dtec_pkg::DTEC_MODE_RELOAD: begin
               ovf = inc && lo_reg == `DTEC_BYTE_MAX;
            end
            dtec_pkg::DTEC_MODE_HALT: begin
               ovf = 1'b0;
            end
         endcase
      end

      // Count bytes; a register write overrides the tick
      always_ff @(posedge sys_clk) begin
         if (srst) begin
            lo_reg <= '0;
            hi_reg <= '0;
         end else begin
            if (inc) begin
               unique case (mode)
                  dtec_pkg::DTEC_MODE_13BIT: begin
                     lo_reg[4:0] <= lo_reg[4:0] + `DTEC_ONE5;
                     if (lo_reg[4:0] == `DTEC_PRESCALE_MAX) begin
                        hi_reg <= hi_reg + `DTEC_ONE8;
                     end
                  end
                  dtec_pkg::DTEC_MODE_16BIT: begin
                     {hi_reg, lo_reg} <= {hi_reg, lo_reg} + `DTEC_ONE16;
                  end
                  dtec_pkg::DTEC_MODE_RELOAD: begin
                     lo_reg <= (lo_reg == `DTEC_BYTE_MAX) ? hi_reg
                        : lo_reg + `DTEC_ONE8;
                  end
                  dtec_pkg::DTEC_MODE_HALT: begin
                  end
               endcase
            end
            if (wr_lo) begin
               lo_reg <= sfr_req.wdata;
            end
            if (wr_hi) begin
               hi_reg <= sfr_req.wdata;
            end
         end
      end

      assign lo_q[i] = lo_reg;
      assign hi_q[i] = hi_reg;
      assign ovf_w[i] = ovf;
      assign inc_w[i] = inc;
   end

   // Flag update: write, then acknowledge, then hardware set wins
   always_comb begin
      ctrl_next = ctrl_reg;
      if (ctrl_wr) begin
         ctrl_next = sfr_req.wdata;
      end
      for (int k = 0; k < 2; k++) begin
         if (ack_tmr[k]) begin
            ctrl_next[`DTEC_TF_BASE + 2*k] = 1'b0;
         end
         if (ovf_w[k]) begin
            ctrl_next[`DTEC_TF_BASE + 2*k] = 1'b1;
         end
         if (ctrl_next[`DTEC_IT_BASE + 2*k]) begin
            if (ack_ext[k]) begin
               ctrl_next[`DTEC_IE_BASE + 2*k] = 1'b0;
            end
            if (int_fall[k]) begin
               ctrl_next[`DTEC_IE_BASE + 2*k] = 1'b1;
            end
         end else begin
            ctrl_next[`DTEC_IE_BASE + 2*k] = ~int_pin[k];
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ctrl_reg <= `DTEC_CTRL_RST;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   // Requests are the flag flops themselves, no extra delay
   assign irq_req.tmr1 = ctrl_reg[`DTEC_TF_BASE + 2];
   assign irq_req.tmr0 = ctrl_reg[`DTEC_TF_BASE];
   assign irq_req.ext1 = ctrl_reg[`DTEC_IE_BASE + 2];
   assign irq_req.ext0 = ctrl_reg[`DTEC_IE_BASE];

   // Registered read data; unmapped addresses read zero
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rdata_reg <= `DTEC_RDATA_RST;
      end else if (sfr_req.rd) begin
         unique case (sfr_req.addr)
            `DTEC_ADDR_CTRL: rdata_reg <= ctrl_reg;
            `DTEC_ADDR_MODE: rdata_reg <= mode_reg;
            `DTEC_ADDR_LO0: rdata_reg <= lo_q[0];
            8'(`DTEC_ADDR_LO0 + 1): rdata_reg <= lo_q[1];
            `DTEC_ADDR_HI0: rdata_reg <= hi_q[0];
            8'(`DTEC_ADDR_HI0 + 1): rdata_reg <= hi_q[1];
            `DTEC_ADDR_CLKSEL: rdata_reg <= clksel_reg;
            default: rdata_reg <= `DTEC_RDATA_RST;
         endcase
      end
   end

   assign sfr_rdata = rdata_reg;

   // Timer registers untouched by the bus this cycle
   logic [1:0] no_tmr_wr;
   assign no_tmr_wr[0] = !(sfr_req.wr &&
      (sfr_req.addr == `DTEC_ADDR_LO0 || sfr_req.addr == `DTEC_ADDR_HI0));
   assign no_tmr_wr[1] = !(sfr_req.wr &&
      (sfr_req.addr == 8'(`DTEC_ADDR_LO0 + 1) ||
       sfr_req.addr == 8'(`DTEC_ADDR_HI0 + 1)));

   // Overflow always raises the flag, even against a clearing write
   a_flag1_on_ovf: assert property (
      @(posedge sys_clk) disable iff (srst)
      ovf_w[1] |=> irq_req.tmr1)
      else $error("timer one overflow did not set flag");

   a_flag0_on_ovf: assert property (
      @(posedge sys_clk) disable iff (srst)
      ovf_w[0] |=> irq_req.tmr0)
      else $error("timer zero overflow did not set flag");

   // Vector acknowledge clears when no overflow competes
   a_flag1_ack_clr: assert property (
      @(posedge sys_clk) disable iff (srst)
      irq_ack.tmr1 && !ovf_w[1] |=> !irq_req.tmr1)
      else $error("timer one flag survived acknowledge");

   a_flag0_ack_clr: assert property (
      @(posedge sys_clk) disable iff (srst)
      irq_ack.tmr0 && !ovf_w[0] |=> !irq_req.tmr0)
      else $error("timer zero flag survived acknowledge");

   // Stopped timer keeps both bytes
   a_one_run_hold: assert property (
      @(posedge sys_clk) disable iff (srst)
      !ctrl_reg[`DTEC_TR_BASE + 2] && no_tmr_wr[1]
      |=> $stable(lo_q[1]) && $stable(hi_q[1]))
      else $error("halted timer one changed");

   a_zero_run_hold: assert property (
      @(posedge sys_clk) disable iff (srst)
      !ctrl_reg[`DTEC_TR_BASE] && no_tmr_wr[0]
      |=> $stable(lo_q[0]) && $stable(hi_q[0]))
      else $error("halted timer zero changed");

   // Edge mode: a falling edge sets the flag next cycle
   a_ext1_edge_set: assert property (
      @(posedge sys_clk) disable iff (srst)
      ctrl_next[`DTEC_IT_BASE + 2] && int_fall[1] |=> irq_req.ext1)
      else $error("interrupt one edge lost");

   // Level mode: flag mirrors inverted pin one cycle later
   a_ext1_level: assert property (
      @(posedge sys_clk) disable iff (srst)
      !ctrl_next[`DTEC_IT_BASE + 2]
      |=> irq_req.ext1 == !$past(ext_irq_one_pin))
      else $error("interrupt one level not mirrored");

   // Gate closed by low pin stops timer one
   a_gate1_off: assert property (
      @(posedge sys_clk) disable iff (srst)
      mode_reg[4 + `DTEC_GATE_BIT] && !ext_irq_one_pin
      |-> !inc_w[1])
      else $error("timer one counted with gate closed");

   // Idle freezes the low bytes of both timers over consecutive cycles
   a_idle_freeze: assert property (
      @(posedge sys_clk) disable iff (srst)
      cpu_idle && no_tmr_wr == 2'b11
      |=> $stable(lo_q[0]) && $stable(lo_q[1]))
      else $error("timer moved while idle");

   // Internal tick spacing is twelve clocks
   a_div12_space: assert property (
      @(posedge sys_clk) disable iff (srst)
      tick12 |=> !tick12 [*8] ##1 !tick12 [*3] ##1 tick12)
      else $error("divide by twelve tick spacing wrong");

endmodule

// ---- verif/dtec_core_model.sv ----
// Purpose: Core-side interrupt vectoring model for dtec_top
// Assumes: One source vectored at a time, lowest bit first
// Notes: Vectors only while ack_en is high, after ack_dly cycles, or 15 cycles after an acknowledge while requests stay pending
`timescale 1ns/1ps

module dtec_core_model (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // Vectoring control from the bench
   input wire logic ack_en,
   input wire logic [3:0] ack_dly,
   // Interrupt lines
   input wire dtec_pkg::dtec_irq_t irq_req,
   output dtec_pkg::dtec_irq_t irq_ack
);
   logic [3:0] wait_reg;

   // Pending request waits, then one acknowledge pulse
   always_ff @(posedge sys_clk) begin
      irq_ack <= '0;
      if (srst || !ack_en || irq_req == '0) begin
         wait_reg <= ack_dly;
      end else if (wait_reg != 4'h0) begin
         wait_reg <= wait_reg - 4'h1;
      end else begin
         irq_ack <= irq_req & ~(irq_req - 4'h1);  // Lowest pending only
         wait_reg <= 4'hf;  // Long gap lets the flag drop first
      end
   end
endmodule

// ---- verif/tb_dtec_top.sv ----
// Purpose: Self-checking bench for dtec_top
// Assumes: Inputs driven on falling edges, one idle cycle per access
// Notes: Tick counts allow one tick of divider phase slack
`timescale 1ns/1ps

module tb_dtec_top;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   dtec_pkg::dtec_sfr_req_t sfr_req = '0;
   logic [7:0] sfr_rdata;
   logic cpu_idle = 1'b0;
   dtec_pkg::dtec_irq_t irq_ack;
   dtec_pkg::dtec_irq_t irq_req;
   logic ext0_pin = 1'b1;
   logic ext1_pin = 1'b1;
   logic cnt0_pin = 1'b1;
   logic cnt1_pin = 1'b1;
   logic ack_en = 1'b0;
   logic [3:0] ack_dly = 4'h2;
   int n_errors = 0;
   int checks = 0;
   logic [7:0] v;

   always #5 sys_clk = ~sys_clk;

   dtec_top dtec_top_i (
      .sys_clk(sys_clk), .srst(srst), .sfr_req(sfr_req),
      .sfr_rdata(sfr_rdata), .cpu_idle(cpu_idle), .irq_ack(irq_ack),
      .irq_req(irq_req), .ext_irq_zero_pin(ext0_pin),
      .ext_irq_one_pin(ext1_pin), .timer_zero_count_pin(cnt0_pin),
      .timer_one_count_pin(cnt1_pin)
   );

   dtec_core_model dtec_core_model_i (
      .sys_clk(sys_clk), .srst(srst), .ack_en(ack_en),
      .ack_dly(ack_dly), .irq_req(irq_req), .irq_ack(irq_ack)
   );

   // Register bus write, one-cycle strobe
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      sfr_req <= '{1'b1, 1'b0, a, d};
      @(negedge sys_clk);
      sfr_req <= '0;
   endtask

   // Register bus read, data settled by the next falling edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge sys_clk);
      sfr_req <= '{1'b0, 1'b1, a, 8'h00};
      @(negedge sys_clk);
      sfr_req <= '0;
      d = sfr_rdata;
   endtask

   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] g;
      rd(a, g);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value reg %h exp %h got %h", a, e, g);
      end
   endtask

   // Bounded wait for one request line
   task automatic wait_irq(input int b);
      int i;
      for (i = 0; i < 40 && irq_req[b] !== 1'b1; i++) begin
         @(negedge sys_clk);
      end
      checks++;
      if (irq_req[b] !== 1'b1) begin
         n_errors++;
         $display("wrong value irq_req bit %0d exp 1 got %b", b, irq_req[b]);
      end
   endtask

   // Timer zero runs 120 cycles; count compared with slack of one
   task automatic span(input logic [7:0] ck, input int e);
      wr(8'h8e, ck);
      wr(8'h8a, 8'h00);
      wr(8'h88, 8'h10);
      repeat (118) @(negedge sys_clk);
      wr(8'h88, 8'h00);
      rd(8'h8a, v);
      checks++;
      if (!(v === 8'(e) || v === 8'(e - 1) || v === 8'(e + 1))) begin
         n_errors++;
         $display("wrong value tick count exp %0d got %h", e, v);
      end
   endtask

   task automatic print_verdict;
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Hang guard, well beyond the expected run of about 700 cycles
   initial begin
      repeat (6000) @(posedge sys_clk);
      n_errors++;
      print_verdict;
   end

   initial begin
      repeat (10) @(negedge sys_clk);
      srst = 1'b0;
      // Reset values and an unmapped address
      rc(8'h88, 8'h00);
      rc(8'h89, 8'h00);
      rc(8'h8e, 8'h01);
      rc(8'h90, 8'h00);
      // Mode 0: low byte bits 7:5 untouched across overflow
      wr(8'h8c, 8'hff);
      wr(8'h8a, 8'hff);
      wr(8'h88, 8'h10);
      wait_irq(1);
      rc(8'h8a, 8'he0);
      rc(8'h8c, 8'h00);
      wr(8'h88, 8'h20);
      ack_en = 1'b1;
      repeat (20) @(negedge sys_clk);
      rc(8'h88, 8'h00);
      ack_en = 1'b0;
      // Stopped timer keeps its count
      wr(8'h8a, 8'h55);
      repeat (40) @(negedge sys_clk);
      rc(8'h8a, 8'h55);
      // Internal tick rates
      wr(8'h89, 8'h01);
      span(8'h01, 120 / 12);
      span(8'h09, 120 / 4);
      // Idle freezes a running timer
      cpu_idle = 1'b1;
      wr(8'h8a, 8'h40);
      wr(8'h88, 8'h10);
      repeat (40) @(negedge sys_clk);
      rc(8'h8a, 8'h40);
      // Mode 3 halts and keeps the count; idle ends once halted
      wr(8'h89, 8'h03);
      cpu_idle = 1'b0;
      repeat (40) @(negedge sys_clk);
      rc(8'h8a, 8'h40);
      // Gated timers with pins low; pins drop before the gate opens
      ext0_pin = 1'b0;
      ext1_pin = 1'b0;
      wr(8'h89, 8'h99);
      wr(8'h8b, 8'h00);
      wr(8'h88, 8'h50);
      repeat (40) @(negedge sys_clk);
      rc(8'h8a, 8'h40);
      rc(8'h8b, 8'h00);
      rc(8'h88, 8'h5a);
      ext0_pin = 1'b1;
      ext1_pin = 1'b1;
      repeat (40) @(negedge sys_clk);
      rc(8'h88, 8'h50);
      rd(8'h8b, v);
      checks++;
      if (v === 8'h00 || $isunknown(v)) begin
         n_errors++;
         $display("wrong value gated count exp moved got %h", v);
      end
      // Edge mode: flags held until vectored
      wr(8'h88, 8'h05);
      ext0_pin = 1'b0;
      ext1_pin = 1'b0;
      repeat (3) @(negedge sys_clk);
      ext0_pin = 1'b1;
      ext1_pin = 1'b1;
      repeat (3) @(negedge sys_clk);
      rc(8'h88, 8'h0f);
      checks++;
      if (irq_req !== 4'b0101) begin
         n_errors++;
         $display("wrong value irq_req exp 5 got %h", irq_req);
      end
      ack_en = 1'b1;
      repeat (40) @(negedge sys_clk);
      rc(8'h88, 8'h05);
      ack_en = 1'b0;
      // Mode 2 reload, then software clear of the flag
      wr(8'h89, 8'h20);
      wr(8'h8d, 8'hfd);
      wr(8'h8b, 8'hff);
      wr(8'h88, 8'h40);
      wait_irq(3);
      rc(8'h8b, 8'hfd);
      rc(8'h88, 8'hc0);
      wr(8'h88, 8'h00);
      rc(8'h88, 8'h00);
      // Counter mode: three falling edges roll over the 16-bit count
      wr(8'h89, 8'h50);
      wr(8'h8d, 8'hff);
      wr(8'h8b, 8'hfe);
      wr(8'h88, 8'h40);
      repeat (3) begin
         cnt1_pin = 1'b0;
         repeat (6) @(negedge sys_clk);
         cnt1_pin = 1'b1;
         repeat (6) @(negedge sys_clk);
      end
      wait_irq(3);
      rc(8'h8b, 8'h01);
      print_verdict;
   end
endmodule
